// ==== rtl/trace_seq_pkg.sv ====
// constants shared by the trace control sequencer and its helpers
package trace_seq_pkg;
	// ============================================================
	// geometry
	localparam int NUM_LEVELS = 16;
	localparam int NUM_ACTIONS = 4;
	localparam int PROBE_W = 48;
	localparam int DELAY_W = 16;
	localparam logic [15:0] DELAY_MAX = 16'hFFFF;
	// action slots
	localparam int ACT_STOP = 0;
	localparam int ACT_JUMP = 1;
	localparam int ACT_ADV = 2;
	localparam int ACT_TRACE = 3;
	// ============================================================
	// condition codes
	localparam logic [3:0] COND_MATCH = 4'h0;
	localparam logic [3:0] COND_ALWAYS = 4'h1;
	localparam logic [3:0] COND_NEVER = 4'h2;
	localparam logic [3:0] COND_GT = 4'h3;
	localparam logic [3:0] COND_LT = 4'h4;
	localparam logic [3:0] COND_EQ = 4'h5;
	localparam logic [3:0] COND_GE = 4'h6;
	localparam logic [3:0] COND_LE = 4'h7;
	localparam logic [3:0] COND_NE = 4'h8;
	// ============================================================
	// register map (byte addresses)
	localparam logic [15:0] OFS_CTRL = 16'h0000;
	localparam logic [15:0] OFS_STATUS = 16'h0004;
	localparam logic [15:0] OFS_IRQ_STAT = 16'h0008;
	localparam logic [15:0] OFS_IRQ_MASK = 16'h000C;
	localparam logic [15:0] OFS_COUNT = 16'h0010;
	localparam logic [15:0] OFS_LEVEL_BASE = 16'h1000;
	// ctrl fields: command pulses and arm mode
	localparam int CTRL_ARM = 0;
	localparam int CTRL_ADV = 1;
	localparam int CTRL_XFER = 2;
	localparam int CTRL_ABORT = 3;
	localparam int CTRL_AUTO = 8;
	// level word fields
	localparam int LVL_UNIT = 16;
	localparam int LVL_TGT_LSB = 20;
	// irq bits
	localparam int IRQ_W = 3;
	localparam int IRQ_STOP = 0;
	localparam int IRQ_XFER = 1;
	localparam int IRQ_ABORT = 2;
	// reset values
	localparam logic [3:0] COND_RST = COND_NEVER;
	localparam logic [15:0] DELAY_RST = 16'h0000;
	localparam logic [2:0] MASK_RST = 3'h0;
endpackage : trace_seq_pkg

// ==== rtl/probe_sync.sv ====
// two-flop synchroniser for the asynchronous probe inputs
`timescale 1ns/10ps
`default_nettype none
module probe_sync #(
	parameter int W = 48
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// first stage is read only by the second
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : probe_sync
`default_nettype wire

// ==== rtl/cond_eval.sv ====
// one conditional action: masked pattern match and count comparison
`timescale 1ns/10ps
`default_nettype none
module cond_eval
	import trace_seq_pkg::*;
(
	// sample and pattern
	input wire logic [PROBE_W-1:0] sample,
	input wire logic [PROBE_W-1:0] value,
	input wire logic [PROBE_W-1:0] care,
	// condition
	input wire logic [3:0] mode,
	input wire logic [DELAY_W-1:0] count,
	input wire logic [DELAY_W-1:0] delay,
	// result
	output logic match,
	output logic fire
);
	// a clear care bit is a don't-care position
	assign match = ((sample ^ value) & care) == '0;

	always_comb begin
		case (mode)
			COND_MATCH: fire = match;
			COND_ALWAYS: fire = 1'b1;
			COND_GT: fire = match && (count > delay);
			COND_LT: fire = match && (count < delay);
			COND_EQ: fire = match && (count == delay);
			COND_GE: fire = match && (count >= delay);
			COND_LE: fire = match && (count <= delay);
			COND_NE: fire = match && (count != delay);
			// never, and unused codes
			default: fire = 1'b0;
		endcase
	end
endmodule : cond_eval
`default_nettype wire

// ==== rtl/trace_trigger_sequencer.sv ====
// multi-level trace control sequencer with an ahb-lite register port
`timescale 1ns/10ps
`default_nettype none
module trace_trigger_sequencer
	import trace_seq_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// raw asynchronous probe lines, synchronised inside
	input wire logic [PROBE_W-1:0] probe_in,
	// capture memory side
	output logic trace_we,
	output logic [PROBE_W-1:0] trace_data,
	output logic xfer_req,
	output logic recording,
	output logic [3:0] level,
	// interrupt
	output logic irq
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} seq_state_t;

	// ============================================================
	// configuration storage
	logic [3:0] cond_reg [NUM_LEVELS][NUM_ACTIONS];
	logic [PROBE_W-1:0] val_reg [NUM_LEVELS][NUM_ACTIONS];
	logic [PROBE_W-1:0] care_reg [NUM_LEVELS][NUM_ACTIONS];
	logic [DELAY_W-1:0] delay_reg [NUM_LEVELS];
	logic unit_reg [NUM_LEVELS];
	logic [3:0] target_reg [NUM_LEVELS];
	logic auto_reg;
	logic [IRQ_W-1:0] mask_reg;
	logic [IRQ_W-1:0] stat_reg;

	seq_state_t state_reg;
	logic [3:0] lvl_reg;
	logic [DELAY_W-1:0] count_reg;
	logic [PROBE_W-1:0] sample;

	// ============================================================
	// bus front end
	logic addr_ok;
	logic wr_pend_reg;
	logic [15:0] waddr_reg;
	logic rd_now;
	logic [15:0] raddr;
	logic cmd_arm, cmd_adv, cmd_xfer, cmd_abort;

	assign addr_ok = hsel && hready && htrans[1];
	assign rd_now = addr_ok && !hwrite;
	assign raddr = haddr[15:0];

	// writes take one wait state so a following read sees the new value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			waddr_reg <= 16'h0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			// every transfer is answered okay
			hresp <= 1'b0;
			wr_pend_reg <= addr_ok && hwrite;
			hreadyout <= !(addr_ok && hwrite);
			if (addr_ok && hwrite) begin
				waddr_reg <= haddr[15:0];
			end
		end
	end

	// level-array decode: level in [11:8], slot in [7:5], word in [4:2]
	logic wr_arr;
	logic [3:0] w_lvl;
	logic [2:0] w_slot;
	logic [2:0] w_word;
	assign wr_arr = wr_pend_reg && (waddr_reg[15:12] == OFS_LEVEL_BASE[15:12]);
	assign w_lvl = waddr_reg[11:8];
	assign w_slot = waddr_reg[7:5];
	assign w_word = waddr_reg[4:2];

	assign cmd_arm = wr_pend_reg && (waddr_reg == OFS_CTRL) && hwdata[CTRL_ARM];
	assign cmd_adv = wr_pend_reg && (waddr_reg == OFS_CTRL) && hwdata[CTRL_ADV];
	assign cmd_xfer = wr_pend_reg && (waddr_reg == OFS_CTRL) && hwdata[CTRL_XFER];
	assign cmd_abort = wr_pend_reg && (waddr_reg == OFS_CTRL) && hwdata[CTRL_ABORT];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			auto_reg <= 1'b0;
			mask_reg <= MASK_RST;
		end else if (wr_pend_reg) begin
			if (waddr_reg == OFS_CTRL) begin
				auto_reg <= hwdata[CTRL_AUTO];
			end else if (waddr_reg == OFS_IRQ_MASK) begin
				mask_reg <= hwdata[IRQ_W-1:0];
			end
		end
	end

	// per-level and per-action storage, one writer per entry
	genvar gl, ga;
	generate
		for (gl = 0; gl < NUM_LEVELS; gl++) begin : g_lvl
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					delay_reg[gl] <= DELAY_RST;
					unit_reg[gl] <= 1'b0;
					target_reg[gl] <= 4'h0;
				end else if (wr_arr && w_lvl == gl && w_slot == 3'h0 && w_word == 3'h0) begin
					delay_reg[gl] <= hwdata[DELAY_W-1:0];
					unit_reg[gl] <= hwdata[LVL_UNIT];
					target_reg[gl] <= hwdata[LVL_TGT_LSB+3:LVL_TGT_LSB];
				end
			end
			for (ga = 0; ga < NUM_ACTIONS; ga++) begin : g_act
				always_ff @(posedge hclk or negedge hresetn) begin
					if (!hresetn) begin
						cond_reg[gl][ga] <= COND_RST;
						val_reg[gl][ga] <= '0;
						care_reg[gl][ga] <= '0;
					end else if (wr_arr && w_lvl == gl && w_slot == 3'(ga + 1)) begin
						case (w_word)
							3'h0: cond_reg[gl][ga] <= hwdata[3:0];
							3'h1: val_reg[gl][ga][31:0] <= hwdata;
							3'h2: val_reg[gl][ga][47:32] <= hwdata[15:0];
							3'h3: care_reg[gl][ga][31:0] <= hwdata;
							3'h4: care_reg[gl][ga][47:32] <= hwdata[15:0];
							default: ;
						endcase
					end
				end
			end
		end
	endgenerate

	// ============================================================
	// read path: decoded in the address phase, data stands in the data phase
	logic [31:0] rd_val;
	logic [3:0] r_lvl;
	logic [1:0] r_act;
	assign r_lvl = raddr[11:8];
	assign r_act = 2'(raddr[7:5] - 3'h1);

	always_comb begin
		rd_val = 32'h0000_0000;
		if (raddr == OFS_CTRL) begin
			rd_val[CTRL_AUTO] = auto_reg;
		end else if (raddr == OFS_STATUS) begin
			rd_val = {24'h000000, lvl_reg, 3'h0, state_reg == ST_RUN};
		end else if (raddr == OFS_IRQ_STAT) begin
			rd_val[IRQ_W-1:0] = stat_reg;
		end else if (raddr == OFS_IRQ_MASK) begin
			rd_val[IRQ_W-1:0] = mask_reg;
		end else if (raddr == OFS_COUNT) begin
			rd_val[DELAY_W-1:0] = count_reg;
		end else if (raddr[15:12] == OFS_LEVEL_BASE[15:12]) begin
			if (raddr[7:5] == 3'h0 && raddr[4:2] == 3'h0) begin
				rd_val = {8'h00, target_reg[r_lvl], 3'h0, unit_reg[r_lvl], delay_reg[r_lvl]};
			end else if (raddr[7:5] >= 3'h1 && raddr[7:5] <= 3'h4) begin
				case (raddr[4:2])
					3'h0: rd_val[3:0] = cond_reg[r_lvl][r_act];
					3'h1: rd_val = val_reg[r_lvl][r_act][31:0];
					3'h2: rd_val[15:0] = val_reg[r_lvl][r_act][47:32];
					3'h3: rd_val = care_reg[r_lvl][r_act][31:0];
					3'h4: rd_val[15:0] = care_reg[r_lvl][r_act][47:32];
					default: rd_val = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_now) begin
			hrdata <= rd_val;
		end
	end

	// ============================================================
	// probe conditioning and action evaluation
	probe_sync #(.W(PROBE_W)) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d(probe_in),
		.q(sample)
	);

	logic [NUM_ACTIONS-1:0] fire;
	logic [NUM_ACTIONS-1:0] match;

	generate
		for (ga = 0; ga < NUM_ACTIONS; ga++) begin : g_eval
			cond_eval u_eval (
				.sample(sample),
				.value(val_reg[lvl_reg][ga]),
				.care(care_reg[lvl_reg][ga]),
				.mode(cond_reg[lvl_reg][ga]),
				.count(count_reg),
				.delay(delay_reg[lvl_reg]),
				.match(match[ga]),
				.fire(fire[ga])
			);
		end
	endgenerate

	// ============================================================
	// sequencer
	logic running;
	logic do_stop;
	logic do_move;
	logic [3:0] next_lvl;
	assign running = (state_reg == ST_RUN);
	// stop wins over every move; an operator advance overrides jump and advance
	assign do_stop = running && (fire[ACT_STOP] || cmd_xfer || cmd_abort);
	assign do_move = running && (cmd_adv || fire[ACT_JUMP] || fire[ACT_ADV]);

	always_comb begin
		if (cmd_adv) begin
			next_lvl = lvl_reg + 4'h1;
		end else if (fire[ACT_JUMP]) begin
			next_lvl = target_reg[lvl_reg];
		end else begin
			next_lvl = lvl_reg + 4'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
			lvl_reg <= 4'h0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (cmd_arm) begin
						state_reg <= ST_RUN;
						lvl_reg <= 4'h0;
					end
				end
				ST_RUN: begin
					if (cmd_arm && !do_stop) begin
						lvl_reg <= 4'h0;
					end else if (do_stop) begin
						// auto mode re-arms only after a stop that copied memory
						state_reg <= (auto_reg && !cmd_abort) ? ST_RUN : ST_IDLE;
						lvl_reg <= 4'h0;
					end else if (do_move) begin
						lvl_reg <= next_lvl;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
					lvl_reg <= 4'h0;
				end
			endcase
		end
	end

	// delay count: clears on any level entry, even a jump to itself
	logic count_evt;
	assign count_evt = unit_reg[lvl_reg] ? match[ACT_ADV] : 1'b1;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= 16'h0000;
		end else if (!running || do_stop || do_move || cmd_arm) begin
			count_reg <= 16'h0000;
		end else if (count_evt && count_reg != DELAY_MAX) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	// ============================================================
	// capture outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trace_we <= 1'b0;
			trace_data <= '0;
			xfer_req <= 1'b0;
			recording <= 1'b0;
			level <= 4'h0;
		end else begin
			// trace decision stands apart from stop, jump and advance
			trace_we <= running && fire[ACT_TRACE];
			trace_data <= sample;
			// abort leaves the display copy untouched
			xfer_req <= do_stop && !cmd_abort;
			recording <= running;
			level <= lvl_reg;
		end
	end

	// ============================================================
	// interrupt status: read clears, a same-cycle event wins
	logic [IRQ_W-1:0] evt;
	assign evt[IRQ_STOP] = running && fire[ACT_STOP];
	assign evt[IRQ_XFER] = do_stop && !cmd_abort;
	assign evt[IRQ_ABORT] = do_stop && cmd_abort;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_reg <= '0;
			irq <= 1'b0;
		end else begin
			if (rd_now && raddr == OFS_IRQ_STAT) begin
				stat_reg <= evt;
			end else begin
				stat_reg <= stat_reg | evt;
			end
			irq <= |(stat_reg & mask_reg);
		end
	end

	// hsize is unused: only whole-word single transfers are supported
	logic unused_ok;
	assign unused_ok = ^hsize;
endmodule : trace_trigger_sequencer
`default_nettype wire

// ==== test/trace_trigger_sequencer_asserts.sv ====
// port checker for the trace control sequencer
`timescale 1ns/10ps
`default_nettype none
module seq_checker
	import trace_seq_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// probes and capture side
	input wire logic [PROBE_W-1:0] probe_in,
	input wire logic trace_we,
	input wire logic [PROBE_W-1:0] trace_data,
	input wire logic xfer_req,
	input wire logic recording,
	input wire logic [3:0] level,
	input wire logic irq
);
	// ============================================================
	// helpers
	logic take;
	assign take = hsel && hready && htrans[1];
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ============================================================
	// assertions
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	a_write_wait: assert property (take && hwrite |=> !hreadyout ##1 hreadyout)
		else $error("write wait state wrong");
	a_read_nowait: assert property (take && !hwrite |=> hreadyout)
		else $error("read got a wait state");
	a_we_running: assert property (trace_we |-> recording || $past(recording))
		else $error("sample recorded while idle");
	a_we_data: assert property (trace_we |-> trace_data == $past(probe_in, 3))
		else $error("recorded sample differs from probes");
	a_xfer_pulse: assert property (xfer_req |=> !xfer_req)
		else $error("transfer request too long");
	a_xfer_running: assert property (xfer_req |-> recording)
		else $error("transfer without a recording");
	a_arm_level0: assert property ($rose(recording) |-> level == 4'h0)
		else $error("run did not start at level zero");
	// ============================================================
	// coverage
	c_xfer: cover property (xfer_req);
	c_irq: cover property ($rose(irq));
	c_top_level: cover property (recording && level == 4'hF);
endmodule : seq_checker
bind trace_trigger_sequencer seq_checker chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .probe_in(probe_in),
	.trace_we(trace_we), .trace_data(trace_data), .xfer_req(xfer_req), .recording(recording),
	.level(level), .irq(irq));
`default_nettype wire

// ==== test/probe_source.sv ====
// behavioural source of the probed system-under-test lines
`timescale 1ns/10ps
`default_nettype none
module probe_source
	import trace_seq_pkg::*;
(
	// clock
	input wire logic hclk,
	// wanted sample and probe lines
	input wire logic [PROBE_W-1:0] want,
	output logic [PROBE_W-1:0] probe
);
	// lines move just after an edge, as a synchronous target would
	always_ff @(posedge hclk) begin
		probe <= want;
	end
endmodule : probe_source
`default_nettype wire

// ==== test/trace_trigger_sequencer_tb.sv ====
// self-checking bench for the trace control sequencer
`timescale 1ns/10ps
`default_nettype none
module trace_trigger_sequencer_tb;
	import trace_seq_pkg::*;
	// ============================================================
	// signals
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [PROBE_W-1:0] want = '0;
	wire [PROBE_W-1:0] probe;
	wire [PROBE_W-1:0] trace_data;
	wire [31:0] hrdata;
	wire [3:0] level;
	wire hreadyout, hresp, trace_we, xfer_req, recording, irq;
	int n_fail = 0;
	int checks = 0;
	int n_xfer = 0;
	logic [31:0] rd;
	initial forever #2 hclk = ~hclk;
	// a transfer request can stand before the bus write that caused it ends
	always @(posedge hclk) begin
		if (xfer_req === 1'b1) n_xfer <= n_xfer + 1;
	end
	probe_source src (.hclk(hclk), .want(want), .probe(probe));
	trace_trigger_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .probe_in(probe), .trace_we(trace_we), .trace_data(trace_data),
		.xfer_req(xfer_req), .recording(recording), .level(level), .irq(irq));
	// ============================================================
	// helpers
	task close_out;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out
	task chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task tick;
		@(posedge hclk);
		#1;
	endtask : tick
	task wait_ready;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 20);
		if (hreadyout !== 1'b1) begin
			n_fail++;
			close_out();
		end
	endtask : wait_ready
	// one single transfer; the address phase holds until hready is seen high
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask : bus
	task wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask : rdc
	function automatic logic [31:0] act(input int l, input int a, input int off);
		return 32'(32'h1000 + l * 256 + 32 * (a + 1) + off);
	endfunction : act
	task set_act(input int l, input int a, input logic [3:0] c, input logic [47:0] v, input logic [47:0] m);
		wr(act(l, a, 0), {28'h0, c});
		wr(act(l, a, 4), v[31:0]);
		wr(act(l, a, 8), {16'h0, v[47:32]});
		wr(act(l, a, 12), m[31:0]);
		wr(act(l, a, 16), {16'h0, m[47:32]});
	endtask : set_act
	// command outputs show by the time the write ends; recording rises on its last edge
	task wait_rec;
		int i;
		i = 0;
		#1;
		while (recording !== 1'b1 && i < 50) begin
			tick();
			i++;
		end
		chk("recording", 1, recording);
		if (recording !== 1'b1) close_out();
	endtask : wait_rec
	// ============================================================
	// scenarios
	task t_regs;
		rdc("status", {16'h0, OFS_STATUS}, 32'h0);
		rdc("ctrl", {16'h0, OFS_CTRL}, 32'h0);
		rdc("count", {16'h0, OFS_COUNT}, 32'h0);
		rdc("stop cond", act(9, ACT_STOP, 0), {28'h0, COND_RST});
		wr(32'h0000_0800, 32'hFFFF_FFFF);
		rdc("unmapped", 32'h0000_0800, 32'h0);
		wr({16'h0, OFS_IRQ_MASK}, 32'h7);
		rdc("mask", {16'h0, OFS_IRQ_MASK}, 32'h7);
		$display("done regs");
	endtask : t_regs
	task t_codes;
		int n;
		int exp_n[9] = '{8, 8, 0, 4, 3, 1, 5, 4, 7};
		wr(32'h1000, 32'h0000_0003);
		for (int c = 0; c < 9; c++) begin
			wr(act(0, ACT_TRACE, 0), 32'(c));
			wr({16'h0, OFS_CTRL}, 32'h1);
			wait_rec();
			n = 0;
			repeat (8) begin
				if (trace_we === 1'b1) n++;
				tick();
			end
			chk("trace pulses", 48'(exp_n[c]), 48'(n));
			n = n_xfer;
			wr({16'h0, OFS_CTRL}, 32'h8);
			repeat (4) tick();
			chk("abort copy", 0, 48'(n_xfer - n));
			chk("abort run", 0, recording);
			rdc("abort irq", {16'h0, OFS_IRQ_STAT}, 32'h4);
		end
		$display("done codes");
	endtask : t_codes
	task t_stop;
		int i;
		wr(act(0, ACT_TRACE, 0), {28'h0, COND_ALWAYS});
		wr(32'h1000, 32'h0050_0003);
		for (int a = ACT_STOP; a <= ACT_ADV; a++) begin
			set_act(0, a, COND_MATCH, 48'h0000_0000_00AB, 48'h0000_0000_00FF);
		end
		wr({16'h0, OFS_CTRL}, 32'h1);
		wait_rec();
		@(posedge hclk);
		want <= 48'hABCD_EF01_23AB;
		i = 0;
		while (xfer_req !== 1'b1 && i < 20) begin
			tick();
			i++;
		end
		chk("copy", 1, xfer_req);
		if (xfer_req !== 1'b1) close_out();
		chk("last sample", 48'hABCD_EF01_23AB, trace_data);
		chk("level held", 0, level);
		tick();
		tick();
		chk("stopped", 0, recording);
		chk("irq up", 1, irq);
		bus(1'b0, {16'h0, OFS_IRQ_STAT}, 32'h0);
		chk("stop event", 48'((1 << IRQ_STOP) | (1 << IRQ_XFER)), 48'(rd));
		rdc("irq cleared", {16'h0, OFS_IRQ_STAT}, 32'h0);
		tick();
		chk("irq down", 0, irq);
		@(posedge hclk);
		want <= '0;
		$display("done stop");
	endtask : t_stop
	task t_jump;
		int n;
		wr(act(0, ACT_STOP, 0), {28'h0, COND_NEVER});
		wr(act(0, ACT_ADV, 0), {28'h0, COND_NEVER});
		set_act(0, ACT_JUMP, COND_EQ, '0, '0);
		wr(32'h1000, 32'h00F0_0005);
		wr(act(15, ACT_JUMP, 0), {28'h0, COND_ALWAYS});
		wr(32'h1F00, 32'h00F0_0000);
		wr({16'h0, OFS_CTRL}, 32'h101);
		wait_rec();
		n = 0;
		while (level !== 4'hF && n < 40) begin
			tick();
			n++;
		end
		chk("cycles to jump", 6, 48'(n));
		if (level !== 4'hF) close_out();
		rdc("count on reentry", {16'h0, OFS_COUNT}, 32'h0);
		rdc("status level", {16'h0, OFS_STATUS}, 32'h0000_00F1);
		wr({16'h0, OFS_CTRL}, 32'h102);
		#1;
		n = 0;
		while (level !== 4'h0 && n < 5) begin
			tick();
			n++;
		end
		chk("forced advance", 0, level);
		if (level !== 4'h0) close_out();
		bus(1'b0, {16'h0, OFS_CTRL}, 32'h0);
		chk("auto mode", 1, rd[CTRL_AUTO]);
		wr({16'h0, OFS_CTRL}, 32'h8);
		wr({16'h0, OFS_CTRL}, 32'h0);
		$display("done jump");
	endtask : t_jump
	// delay counted in advance-pattern occurrences rather than clocks
	task t_unit;
		wr(act(0, ACT_JUMP, 0), {28'h0, COND_NEVER});
		wr(32'h1000, 32'h0001_0002);
		wr({16'h0, OFS_CTRL}, 32'h1);
		wait_rec();
		repeat (4) tick();
		rdc("count no match", {16'h0, OFS_COUNT}, 32'h0);
		@(posedge hclk);
		want <= 48'h0000_0000_00AB;
		repeat (3) @(posedge hclk);
		want <= '0;
		repeat (6) tick();
		rdc("count matches", {16'h0, OFS_COUNT}, 32'h3);
		wr({16'h0, OFS_CTRL}, 32'h8);
		$display("done unit");
	endtask : t_unit
	// ============================================================
	// main sequence
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_codes();
		t_stop();
		t_jump();
		t_unit();
		close_out();
	end
endmodule : trace_trigger_sequencer_tb
`default_nettype wire
